// *** vrsp_command_port.sv ***
// serial command port: frame shifter, decoder and operation sequencer
`timescale 1ns/100ps
module vrsp_command_port
  import vrsp_pkg::*;
#(
  parameter int          PUD_CYCLES = vrsp_pkg::PUD_CYC,
  parameter int          ROW_CYCLES = vrsp_pkg::ROW_CYC,
  parameter logic [15:0] LAST_ROW   = vrsp_pkg::ROW_LAST
)
(
  input  wire logic              CLOCK,
  input  wire logic              NRST,
  input  wire logic              CE,
  input  wire logic              SCLK,
  input  wire logic              SS_N,
  input  wire logic              MOSI,
  input  wire logic              EOM_MARK,
  output      logic              MISO,
  output      logic              MISO_OE_N,
  output      logic              INT_N,
  output      logic              RUN,
  output      vrsp_pkg::vrsp_mode_t OP_MODE,
  output      logic              POWERED,
  output      logic              READY,
  output      logic [15:0]       ROW_ADDR,
  output      logic [15:0]       CONFIGURATION_REGISTER_ZERO,
  output      logic [15:0]       CONFIGURATION_REGISTER_ONE
);
  import vrsp_pkg::*;

  localparam int CUE_CYCLES = (ROW_CYCLES / CUE_RATIO < 1) ? 1
                              : ROW_CYCLES / CUE_RATIO;
  localparam int PW = $clog2(PUD_CYCLES + 1);
  localparam int RW = $clog2(ROW_CYCLES + 1);

  typedef struct packed {
    logic             sclk_m;
    logic             sclk_s;
    logic             sclk_d;
    logic             ss_m;
    logic             ss_s;
    logic             ss_d;
    logic             mosi_m;
    logic             mosi_s;
    logic [4:0]       cnt;
    logic [23:0]      shin;
    logic [23:0]      shout;
    logic             miso;
    logic             miso_oe_n;
    vrsp_mode_t       mode;
    logic             run;
    logic             powered;
    logic             ready;
    logic [PW-1:0]    pud;
    logic [RW-1:0]    pre;
    logic [15:0]      row;
    logic [15:0]      configuration_register_zero;
    logic [15:0]      configuration_register_one;
    logic [15:0]      configuration_register_zero_pend;
    logic             end_of_message_flag;
    logic             ovf;
    logic             int_n;
  } vrsp_state_t;

  localparam vrsp_state_t ST_RST = '{
    ss_m: 1'b1, ss_s: 1'b1, ss_d: 1'b1, miso_oe_n: 1'b1, int_n: 1'b1,
    mode: VRSP_IDLE, configuration_register_zero: CONFIGURATION_REGISTER_ZERO_RST, configuration_register_one: CONFIGURATION_REGISTER_ONE_RST,
    configuration_register_zero_pend: CONFIGURATION_REGISTER_ZERO_RST, default: '0};

  function automatic logic op_match(input logic [7:0] op,
                                    input logic [7:0] val,
                                    input logic [7:0] mask);
    op_match = (op & mask) == (val & mask);
  endfunction

  logic        rst_m;
  logic        rst_n;
  vrsp_state_t st;
  vrsp_state_t next_st;

  logic        sck_rise;
  logic        sck_fall;
  logic        ss_fall;
  logic        ss_rise;
  logic        frame_done;
  logic        step;
  logic        ev_eom;
  logic        ev_ovf;
  logic [7:0]  op;
  logic [15:0] field;
  logic        cmd_start;
  logic [RW-1:0] period;

  // reset enters asynchronously, leaves through two flops
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  always_comb
  begin
    next_st = st;
    next_st.sclk_m = SCLK;
    next_st.sclk_s = st.sclk_m;
    next_st.sclk_d = st.sclk_s;
    next_st.ss_m   = SS_N;
    next_st.ss_s   = st.ss_m;
    next_st.ss_d   = st.ss_s;
    next_st.mosi_m = MOSI;
    next_st.mosi_s = st.mosi_m;

    sck_rise   = st.sclk_s & ~st.sclk_d & ~st.ss_s;
    sck_fall   = ~st.sclk_s & st.sclk_d & ~st.ss_s;
    ss_fall    = st.ss_d & ~st.ss_s;
    ss_rise    = ~st.ss_d & st.ss_s;
    frame_done = ss_rise && st.cnt == FRAME_CNT;
    op         = st.shin[23:16];
    field      = st.shin[15:0];

    // status loaded at select fall so its first bit is ready early
    if (ss_fall)
    begin
      next_st.cnt = '0;
      next_st.shout = {6'h00, st.ovf, st.end_of_message_flag, st.row};
      next_st.miso = next_st.shout[23];
    end
    if (sck_rise && st.cnt != FRAME_CNT)
    begin
      next_st.shin = {st.shin[22:0], st.mosi_s};
      next_st.cnt = st.cnt + 5'h01;
    end
    if (sck_fall)
    begin
      next_st.shout = {st.shout[22:0], 1'b0};
      next_st.miso = st.shout[22];
    end
    next_st.miso_oe_n = st.ss_s;

    // array stepping; cue uses a shorter row period
    period = (st.mode == VRSP_CUE) ? RW'(CUE_CYCLES - 1)
             : RW'(ROW_CYCLES - 1);
    step = 1'b0;
    if (st.run)
    begin
      if (st.pre == period)
      begin
        next_st.pre = '0;
        step = 1'b1;
      end
      else
        next_st.pre = st.pre + RW'(1);
    end
    ev_ovf = step && st.row == LAST_ROW;
    ev_eom = step && !ev_ovf && st.mode != VRSP_REC && EOM_MARK;
    if (step && !ev_ovf)
      next_st.row = st.row + 16'h0001;
    if (ev_ovf || ev_eom)
    begin
      next_st.run = 1'b0;
      next_st.mode = VRSP_IDLE;
    end

    cmd_start = op_match(op, OPC_SPLAY, MASK_ALL)
              | op_match(op, OPC_PLAY, MASK_ALL)
              | op_match(op, OPC_SREC, MASK_ALL)
              | op_match(op, OPC_REC, MASK_ALL)
              | op_match(op, OPC_CUE, MASK_ALL);

    if (frame_done)
    begin
      if (op_match(op, OPC_PWR_ON, MASK_ALL))
        next_st.powered = 1'b1;
      if (op_match(op, OPC_CONFIGURATION_REGISTER_ZERO, MASK_CFG))
        next_st.configuration_register_zero_pend = field;
      if (op_match(op, OPC_CONFIGURATION_REGISTER_ONE, MASK_CFG))
      begin
        next_st.configuration_register_one = field;
        next_st.configuration_register_zero = st.configuration_register_zero_pend;
      end
      if (op_match(op, OPC_STOP, MASK_STOP))
      begin
        next_st.run = 1'b0;
        next_st.mode = VRSP_IDLE;
      end
      if (op_match(op, OPC_SLEEP, MASK_STOP))
      begin
        next_st.run = 1'b0;
        next_st.mode = VRSP_IDLE;
        next_st.powered = 1'b0;
        next_st.ready = 1'b0;
        next_st.pud = '0;
      end
      if (cmd_start)
      begin
        next_st.run = 1'b1;
        next_st.pre = '0;
        next_st.mode = op[OP_MC] ? VRSP_CUE
                     : op[OP_PLAY] ? VRSP_PLAY : VRSP_REC;
        if (!op[4])
          next_st.row = field;
      end
    end

    // a flag raised in the closing cycle survives the clear
    next_st.end_of_message_flag = (st.end_of_message_flag & ~frame_done) | ev_eom;
    next_st.ovf = (st.ovf & ~frame_done) | ev_ovf;
    next_st.int_n = ~(next_st.end_of_message_flag | next_st.ovf);

    // ready is advisory; commands are not held off before it
    // next power state, so a sleep frame also stops the count
    if (next_st.powered && !st.ready)
    begin
      if (st.pud == PW'(PUD_CYCLES - 1))
        next_st.ready = 1'b1;
      else
        next_st.pud = st.pud + PW'(1);
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      st <= ST_RST;
    else if (CE)
      st <= next_st;
  end

  assign MISO      = st.miso;
  assign MISO_OE_N = st.miso_oe_n;
  assign INT_N     = st.int_n;
  assign RUN       = st.run;
  assign OP_MODE   = st.mode;
  assign POWERED   = st.powered;
  assign READY     = st.ready;
  assign ROW_ADDR  = st.row;
  assign CONFIGURATION_REGISTER_ZERO      = st.configuration_register_zero;
  assign CONFIGURATION_REGISTER_ONE      = st.configuration_register_one;

  default clocking dc @(posedge CLOCK);
  endclocking
  default disable iff (!rst_n);

  sequence frame_close;
    CE && frame_done;
  endsequence

  sequence start_frame;
    frame_close ##0 cmd_start;
  endsequence

  sequence select_open;
    CE && ss_fall;
  endsequence

  exec_start_a: assert property (start_frame |=> st.run)
    else $error("start frame did not set run");
  run_mode_a: assert property (st.run == (st.mode != VRSP_IDLE))
    else $error("run bit and mode disagree");
  int_clear_a: assert property (
    frame_close ##0 !ev_eom && !ev_ovf |=> st.int_n && !st.end_of_message_flag)
    else $error("interrupt not cleared by frame");
  int_set_a: assert property (
    CE && (ev_eom || ev_ovf) |=> !st.int_n
    && (!st.run || $past(frame_done && cmd_start)))
    else $error("end event did not interrupt and stop");
  cfg_hold_a: assert property (
    frame_close ##0 !op_match(op, OPC_CONFIGURATION_REGISTER_ONE, MASK_CFG)
    |=> st.configuration_register_zero == $past(st.configuration_register_zero))
    else $error("config zero changed without config one load");
  cfg_commit_a: assert property (
    frame_close ##0 op_match(op, OPC_CONFIGURATION_REGISTER_ONE, MASK_CFG)
    |=> st.configuration_register_one == $past(field) && st.configuration_register_zero == $past(st.configuration_register_zero_pend))
    else $error("config load not committed");
  sample_edge_a: assert property (
    CE && sck_rise && st.cnt != FRAME_CNT
    |=> st.shin[0] == $past(st.mosi_s) && !$stable(st.cnt))
    else $error("input bit not taken on rising edge");
  out_edge_a: assert property (
    CE && sck_fall |=> st.miso == $past(st.shout[22]))
    else $error("output bit not moved on falling edge");
  overflow_a: assert property (
    CE && step && st.row == LAST_ROW |=> st.ovf ##1 !st.run)
    else $error("array end did not overflow");
  addr_load_a: assert property (
    start_frame ##0 !op[4] |=> st.row == $past(field))
    else $error("frame address not loaded");
  sleep_a: assert property (
    frame_close ##0 op_match(op, OPC_SLEEP, MASK_STOP)
    |=> !st.powered && !st.run)
    else $error("halt and sleep not obeyed");
  status_load_a: assert property (
    select_open |=> st.shout == {6'h00, $past(st.ovf), $past(st.end_of_message_flag),
    $past(st.row)} && !st.miso)
    else $error("status word not loaded at select fall");
  oe_follow_a: assert property (
    CE |=> st.miso_oe_n == $past(st.ss_s))
    else $error("output enable does not follow select");
  short_frame_a: assert property (
    CE && ss_rise && st.cnt != FRAME_CNT
    |=> st.configuration_register_one == $past(st.configuration_register_one) && st.powered == $past(st.powered))
    else $error("incomplete frame was executed");
  rec_no_eom_a: assert property (
    CE && step && st.mode == VRSP_REC && st.row != LAST_ROW
    && !frame_done |=> st.run)
    else $error("record stopped before array end");
  ready_set_a: assert property (
    CE && st.powered && !st.ready && !frame_done
    && st.pud == PW'(PUD_CYCLES - 1) |=> st.ready)
    else $error("ready not raised after power-on delay");
  freeze_a: assert property (
    !CE |=> $stable(st.row) && $stable(st.run) && $stable(st.pre))
    else $error("state moved while clock enable low");

endmodule

// *** vrsp_pkg.sv ***
// constants and types shared by the voice recorder serial command port
package vrsp_pkg;

  localparam int FRAME_BITS = 24;
  localparam int OP_BITS    = 8;
  localparam int FIELD_BITS = 16;
  localparam logic [4:0] FRAME_CNT = 5'h18;

  // control bit positions inside the opcode byte
  localparam int OP_RUN  = 7;
  localparam int OP_PLAY = 6;
  localparam int OP_MC   = 3;

  // opcode values and compare masks, zero mask bits are don't care
  localparam logic [7:0] OPC_PWR_ON = 8'h20;
  localparam logic [7:0] OPC_CONFIGURATION_REGISTER_ZERO   = 8'h02;
  localparam logic [7:0] OPC_CONFIGURATION_REGISTER_ONE   = 8'h04;
  localparam logic [7:0] OPC_SPLAY  = 8'hE0;
  localparam logic [7:0] OPC_PLAY   = 8'hF0;
  localparam logic [7:0] OPC_SREC   = 8'hA0;
  localparam logic [7:0] OPC_REC    = 8'hB0;
  localparam logic [7:0] OPC_CUE    = 8'hF8;
  localparam logic [7:0] OPC_STOP   = 8'h30;
  localparam logic [7:0] OPC_SLEEP  = 8'h10;
  localparam logic [7:0] MASK_ALL   = 8'hFF;
  localparam logic [7:0] MASK_CFG   = 8'hDF;
  localparam logic [7:0] MASK_STOP  = 8'hBF;

  // status byte bit positions on the serial output
  localparam int STAT_OVF = 1;
  localparam int STAT_EOM = 0;

  localparam logic [15:0] CONFIGURATION_REGISTER_ZERO_RST = 16'h0000;
  localparam logic [15:0] CONFIGURATION_REGISTER_ONE_RST = 16'h0000;
  localparam logic [15:0] ROW_LAST = 16'hFFFF;

  // power-on delay and array timing
  localparam int PUD_US    = 25000;
  localparam int CLK_KHZ   = 10000;
  localparam int PUD_CYC   = (PUD_US * CLK_KHZ + 999) / 1000;
  localparam int CUE_RATIO = 1600;
  localparam int ROW_CYC   = 16000;

  typedef enum logic [1:0] {
    VRSP_IDLE = 2'h0,
    VRSP_PLAY = 2'h1,
    VRSP_CUE  = 2'h3,
    VRSP_REC  = 2'h2
  } vrsp_mode_t;

endpackage

// *** vrsp_host_model.sv ***
// host side serial master model for the command port
`timescale 1ns/100ps
module vrsp_host_model
(
  input  wire logic CLOCK,
  input  wire logic MISO,
  output logic      SCLK,
  output logic      SS_N,
  output logic      MOSI
);
  initial
  begin
    SCLK = 1'b0;
    SS_N = 1'b1;
    MOSI = 1'b0;
  end

  // half a link clock period, 400 ns at the 100 ns system clock
  task automatic half();
    repeat (4) @(negedge CLOCK);
  endtask

  // n below 24 makes a short frame on purpose
  task automatic xfer(input logic [23:0] tx, input int n,
                      output logic [23:0] rx);
    rx = 24'h000000;
    @(negedge CLOCK);
    SS_N = 1'b0;
    half();
    for (int i = 23; i > 23 - n; i--)
    begin
      MOSI = tx[i];
      half();
      SCLK = 1'b1;
      half();
      rx[i] = MISO;
      SCLK = 1'b0;
    end
    // released data line must not look like held data
    MOSI = ~MOSI;
    half();
    SS_N = 1'b1;
    half();
    half();
  endtask
endmodule

// *** vrsp_command_port_tb.sv ***
// self-checking bench for the serial command port
`timescale 1ns/100ps
`define CHK(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); \
    end \
  end
module vrsp_command_port_tb;
  import vrsp_pkg::*;
  logic        clock, nrst, ce, eom_mark, sclk, ss_n, mosi;
  logic        miso, miso_oe_n, miso_w, int_n, run, powered, ready;
  vrsp_mode_t  op_mode;
  logic [15:0] row_addr, configuration_register_zero, configuration_register_one;
  logic [23:0] rx;
  int          fails, checks;

  // deselected output never shows the stale value itself, only its inverse
  assign miso_w = miso_oe_n ? ~miso : miso;

  vrsp_host_model host (.CLOCK(clock), .MISO(miso_w), .SCLK(sclk),
    .SS_N(ss_n), .MOSI(mosi));

  vrsp_command_port #(.PUD_CYCLES(20), .ROW_CYCLES(1600),
    .LAST_ROW(16'h0010)) DUT (.CLOCK(clock), .NRST(nrst), .CE(ce),
    .SCLK(sclk), .SS_N(ss_n), .MOSI(mosi), .EOM_MARK(eom_mark),
    .MISO(miso), .MISO_OE_N(miso_oe_n), .INT_N(int_n), .RUN(run),
    .OP_MODE(op_mode), .POWERED(powered), .READY(ready),
    .ROW_ADDR(row_addr), .CONFIGURATION_REGISTER_ZERO(configuration_register_zero), .CONFIGURATION_REGISTER_ONE(configuration_register_one));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // sel 1 waits on ready, sel 0 on run
  task automatic wait_on(input bit sel, input logic v, input int lim);
    int n;
    n = 0;
    while (((sel ? ready : run) !== v) && n < lim)
    begin
      @(negedge clock);
      n++;
    end
    if ((sel ? ready : run) !== v)
    begin
      fails++;
      end_of_test();
    end
  endtask

  task automatic send(input logic [7:0] op, input logic [15:0] f);
    host.xfer({op, f}, 24, rx);
  endtask

  task automatic t_power();
    send(OPC_PWR_ON, 16'hFFFF);
    `CHK(powered, 1'b1)
    wait_on(1'b1, 1'b1, 100);
    send(8'h22, 16'h1234);
    `CHK(configuration_register_zero, 16'h0000)
    send(8'h04, 16'h5678);
    `CHK(configuration_register_zero, 16'h1234)
    `CHK(configuration_register_one, 16'h5678)
  endtask

  task automatic t_play();
    send(OPC_SPLAY, 16'h0005);
    `CHK(rx, 24'h000000)
    `CHK(run, 1'b1)
    `CHK(op_mode, VRSP_PLAY)
    `CHK(row_addr, 16'h0005)
    @(negedge clock);
    eom_mark = 1'b1;
    wait_on(1'b0, 1'b0, 2000);
    `CHK(row_addr, 16'h0006)
    `CHK(int_n, 1'b0)
    `CHK(op_mode, VRSP_IDLE)
    eom_mark = 1'b0;
    send(OPC_STOP, 16'h0000);
    `CHK(rx, 24'h010006)
    `CHK(int_n, 1'b1)
    host.xfer({OPC_SPLAY, 16'h0009}, 16, rx);
    `CHK(run, 1'b0)
    `CHK(row_addr, 16'h0006)
  endtask

  task automatic t_record();
    send(OPC_SREC, 16'h000F);
    `CHK(op_mode, VRSP_REC)
    @(negedge clock);
    eom_mark = 1'b1;
    wait_on(1'b0, 1'b0, 5000);
    `CHK(row_addr, 16'h0010)
    `CHK(int_n, 1'b0)
    send(8'h70, 16'h0000);
    `CHK(rx, 24'h020010)
  endtask

  task automatic t_cue();
    send(OPC_SPLAY, 16'h0003);
    send(OPC_STOP, 16'h0000);
    `CHK(run, 1'b0)
    `CHK(int_n, 1'b1)
    send(OPC_CUE, 16'h0000);
    wait_on(1'b0, 1'b0, 100);
    `CHK(row_addr, 16'h0004)
    `CHK(int_n, 1'b0)
    @(negedge clock);
    eom_mark = 1'b0;
    send(OPC_CUE, 16'h0000);
    `CHK(op_mode, VRSP_CUE)
    `CHK(row_addr, 16'h0009)
    ce = 1'b0;
    repeat (4) @(negedge clock);
    `CHK(row_addr, 16'h0009)
    `CHK(op_mode, VRSP_CUE)
    ce = 1'b1;
    wait_on(1'b0, 1'b0, 100);
    `CHK(row_addr, 16'h0010)
    `CHK(int_n, 1'b0)
    send(OPC_PLAY, 16'h00AA);
    `CHK(rx, 24'h020010)
    `CHK(run, 1'b1)
    `CHK(row_addr, 16'h0010)
    send(8'h50, 16'h0000);
    `CHK(run, 1'b0)
    `CHK(powered, 1'b0)
  endtask

  initial
  begin
    fails = 0;
    checks = 0;
    nrst = 1'b0;
    ce = 1'b1;
    eom_mark = 1'b0;
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    `CHK(run, 1'b0)
    `CHK(int_n, 1'b1)
    `CHK(miso_oe_n, 1'b1)
    `CHK(configuration_register_one, 16'h0000)
    t_power();
    t_play();
    t_record();
    t_cue();
    end_of_test();
  end
endmodule
